// file: sid_map.svh
// constants for the status indicator driver: timing and reset values
// assumes a 250 MHz system clock; included by the modules
`ifndef SID_MAP_SVH
`define SID_MAP_SVH

`define SID_CLK_HZ        250000000
`define SID_SLOW_HZ       1
`define SID_FAST_HZ       4
// half period in cycles for a 50 percent duty cycle
`define SID_SLOW_HALF     (`SID_CLK_HZ / (2 * `SID_SLOW_HZ))
`define SID_FAST_HALF     (`SID_CLK_HZ / (2 * `SID_FAST_HZ))
`define SID_LAMP_RST      1'h0

`endif

// file: sid_pkg.sv
// types shared by the status indicator driver modules
// assumes sid_map.svh for all numeric constants
package sid_pkg;

  // =========================================================
  // lamp groups
  typedef struct packed {
    logic green;
    logic red;
  } sid_module_lamps_type;

  typedef struct packed {
    logic activity;
    logic link;
  } sid_port_lamps_type;

  // =========================================================
  // device conditions
  typedef struct packed {
    logic self_test;
    logic major_fault;
    logic minor_fault;
    logic has_address;
    logic configured;
  } sid_module_cond_type;

  typedef struct packed {
    logic self_test;
    logic has_address;
    logic dup_address;
    logic conn_up;
    logic timeout_evt;
    logic reestablished;
  } sid_port_cond_type;

  typedef enum logic [2:0] {
    SID_MS_TEST  = 3'h0,
    SID_MS_MAJOR = 3'h1,
    SID_MS_MINOR = 3'h2,
    SID_MS_NOADR = 3'h3,
    SID_MS_STBY  = 3'h4,
    SID_MS_OPER  = 3'h5
  } sid_module_state_type;

  typedef enum logic [2:0] {
    SID_NS_TEST  = 3'h0,
    SID_NS_OFF   = 3'h1,
    SID_NS_DUP   = 3'h2,
    SID_NS_TMO   = 3'h3,
    SID_NS_CONN  = 3'h4,
    SID_NS_NOCON = 3'h5
  } sid_port_state_type;

endpackage

// file: sid_port_ind.sv
// one network indicator: yellow activity and green link lamp
// assumes conditions synchronous to clk_i and a shared slow blink phase
`timescale 1ns/1ns
`include "sid_map.svh"

module sid_port_ind
  import sid_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // slow blink phase
  input  wire logic               slow_i,
  // conditions and lamps
  input  wire sid_port_cond_type  cond_i,
  output sid_port_lamps_type      lamps_o
);

  typedef struct packed {
    logic               tmo_pend;
    sid_port_state_type st;
    sid_port_lamps_type lamps;
  } sid_port_reg_type;

  sid_port_reg_type r_r;
  sid_port_reg_type r_nxt;

  // ==========================================================
  // indication selection
  always_comb begin
    r_nxt = r_r;
    // set wins over re-establish in the same cycle
    if (cond_i.timeout_evt) begin
      r_nxt.tmo_pend = 1'b1; // R11
    end else if (cond_i.reestablished) begin
      r_nxt.tmo_pend = 1'b0; // R12
    end
    if (cond_i.self_test) begin
      r_nxt.st = SID_NS_TEST; // R15
    end else if (!cond_i.has_address) begin
      r_nxt.st = SID_NS_OFF;
    end else if (cond_i.dup_address) begin
      r_nxt.st = SID_NS_DUP;
    end else if (r_r.tmo_pend) begin
      r_nxt.st = SID_NS_TMO;
    end else if (cond_i.conn_up) begin
      r_nxt.st = SID_NS_CONN;
    end else begin
      r_nxt.st = SID_NS_NOCON;
    end
    unique case (r_nxt.st)
      SID_NS_TEST: begin
        r_nxt.lamps.activity = slow_i; // R14
        r_nxt.lamps.link     = !slow_i;
      end
      SID_NS_OFF: begin
        r_nxt.lamps = '0; // R8
      end
      SID_NS_DUP: begin
        r_nxt.lamps.activity = 1'b1; // R13
        r_nxt.lamps.link     = 1'b0;
      end
      SID_NS_TMO: begin
        r_nxt.lamps.activity = slow_i; // R11 R16
        r_nxt.lamps.link     = 1'b0;
      end
      SID_NS_CONN: begin
        r_nxt.lamps.activity = 1'b0;
        r_nxt.lamps.link     = 1'b1; // R9
      end
      SID_NS_NOCON: begin
        r_nxt.lamps.activity = 1'b0;
        r_nxt.lamps.link     = slow_i; // R10 R16
      end
      default: begin
        r_nxt.lamps = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_r <= '{tmo_pend: 1'b0, st: SID_NS_OFF,
               lamps: '{`SID_LAMP_RST, `SID_LAMP_RST}};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign lamps_o = r_r.lamps;

  // ==========================================================
  // checks
  chk_tmo_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    r_r.tmo_pend && !cond_i.reestablished |=> r_r.tmo_pend) // R12
    else $error("timeout indication cleared without re-establish");
  chk_dup_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    !cond_i.self_test && cond_i.has_address && cond_i.dup_address
    |=> lamps_o.activity && !lamps_o.link) // R13
    else $error("duplicate address not steady yellow");
  chk_noaddr_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    !cond_i.self_test && !cond_i.has_address |=> lamps_o == '0) // R8
    else $error("network lamps lit without address");

endmodule

// file: sid_status_indicator.sv
// status lamp driver: module indicator plus two network indicators
// assumes condition inputs synchronous to clk_i, lamps active high
//
// Overview of operation
// [R1] Two network indicators (yellow, green) and a module one (green, red).
// [R2] A healthy operating device shows a steady green module lamp.
// [R3] An unconfigured device flashes the module green lamp at 1 Hz.
// [R4] A device without any address flashes the module green lamp at 4 Hz.
// [R5] A minor recoverable fault flashes the module red lamp.
// [R6] A major fault holds the module red lamp steadily on.
// [R7] Self-test alternates the module red and green lamps.
// [R8] Without an address the network lamps are dark.
// [R9] With at least one connection the network green lamp is steady.
// [R10] With an address but no connection the network green lamp flashes.
// [R11] A connection timeout flashes the network yellow lamp.
// [R12] The timeout indication ends only on re-establish or reset.
// [R13] A duplicate address holds the network yellow lamp steadily on.
// [R14] Self-test alternates the network yellow and green lamps.
// [R15] Precedence: test, major, minor, no address, standby; dup, timeout.
// [R16] Flashing is 50 percent duty; network flashing runs at 1 Hz.
`timescale 1ns/1ns
`include "sid_map.svh"

module sid_status_indicator
  import sid_pkg::*;
#(
  parameter int unsigned SLOW_HALF = `SID_SLOW_HALF,
  parameter int unsigned FAST_HALF = `SID_FAST_HALF
)(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // module conditions
  input  wire sid_module_cond_type  mod_cond_i,
  // network port conditions
  input  wire sid_port_cond_type    port_one_cond_i,
  input  wire sid_port_cond_type    port_two_cond_i,
  // lamps
  output logic                      module_green_lamp_o,
  output logic                      module_red_lamp_o,
  output logic                      port_one_activity_lamp_o,
  output logic                      port_one_link_lamp_o,
  output logic                      port_two_activity_lamp_o,
  output logic                      port_two_link_lamp_o
);

  // refuse halves the shared counter width cannot serve
  if (SLOW_HALF < 2 || FAST_HALF < 1 ||
      FAST_HALF >= SLOW_HALF) begin : g_bad_half
    $error("blink half periods out of range");
  end

  localparam int CW = $clog2(SLOW_HALF + 1);

  typedef struct packed {
    logic [CW-1:0]        slow_cnt;
    logic [CW-1:0]        fast_cnt;
    logic                 slow_ph;
    logic                 fast_ph;
    sid_module_state_type st;
    sid_module_lamps_type lamps;
  } sid_top_reg_type;

  sid_top_reg_type    r_r;
  sid_top_reg_type    r_nxt;
  sid_port_lamps_type p1_lamps;
  sid_port_lamps_type p2_lamps;

  // ==========================================================
  // blink generators and module indicator
  always_comb begin
    r_nxt = r_r;
    // free running half-period counters give 50 percent duty
    if (r_r.slow_cnt == CW'(SLOW_HALF - 1)) begin
      r_nxt.slow_cnt = '0; // R16
      r_nxt.slow_ph  = !r_r.slow_ph;
    end else begin
      r_nxt.slow_cnt = r_r.slow_cnt + CW'(1);
    end
    if (r_r.fast_cnt == CW'(FAST_HALF - 1)) begin
      r_nxt.fast_cnt = '0;
      r_nxt.fast_ph  = !r_r.fast_ph;
    end else begin
      r_nxt.fast_cnt = r_r.fast_cnt + CW'(1);
    end
    if (mod_cond_i.self_test) begin
      r_nxt.st = SID_MS_TEST; // R15
    end else if (mod_cond_i.major_fault) begin
      r_nxt.st = SID_MS_MAJOR;
    end else if (mod_cond_i.minor_fault) begin
      r_nxt.st = SID_MS_MINOR;
    end else if (!mod_cond_i.has_address) begin
      r_nxt.st = SID_MS_NOADR;
    end else if (!mod_cond_i.configured) begin
      r_nxt.st = SID_MS_STBY;
    end else begin
      r_nxt.st = SID_MS_OPER;
    end
    unique case (r_nxt.st)
      SID_MS_TEST: begin
        r_nxt.lamps.green = !r_r.slow_ph; // R7
        r_nxt.lamps.red   = r_r.slow_ph;
      end
      SID_MS_MAJOR: begin
        r_nxt.lamps.green = 1'b0;
        r_nxt.lamps.red   = 1'b1; // R6
      end
      SID_MS_MINOR: begin
        r_nxt.lamps.green = 1'b0;
        r_nxt.lamps.red   = r_r.slow_ph; // R5
      end
      SID_MS_NOADR: begin
        r_nxt.lamps.green = r_r.fast_ph; // R4
        r_nxt.lamps.red   = 1'b0;
      end
      SID_MS_STBY: begin
        r_nxt.lamps.green = r_r.slow_ph; // R3
        r_nxt.lamps.red   = 1'b0;
      end
      SID_MS_OPER: begin
        r_nxt.lamps.green = 1'b1; // R2
        r_nxt.lamps.red   = 1'b0;
      end
      default: begin
        r_nxt.lamps = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_r <= '{slow_cnt: '0, fast_cnt: '0, slow_ph: 1'b0, fast_ph: 1'b0,
               st: SID_MS_TEST,
               lamps: '{`SID_LAMP_RST, `SID_LAMP_RST}};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // network indicators, one per port
  sid_port_ind u_port_one (  // R1
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .slow_i  (r_r.slow_ph),
    .cond_i  (port_one_cond_i),
    .lamps_o (p1_lamps)
  );

  sid_port_ind u_port_two (  // R1
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .slow_i  (r_r.slow_ph),
    .cond_i  (port_two_cond_i),
    .lamps_o (p2_lamps)
  );

  assign module_green_lamp_o      = r_r.lamps.green;
  assign module_red_lamp_o        = r_r.lamps.red;
  assign port_one_activity_lamp_o = p1_lamps.activity;
  assign port_one_link_lamp_o     = p1_lamps.link;
  assign port_two_activity_lamp_o = p2_lamps.activity;
  assign port_two_link_lamp_o     = p2_lamps.link;

  // ==========================================================
  // checks
  logic oper_c;
  logic major_c;
  assign oper_c  = !mod_cond_i.self_test && !mod_cond_i.major_fault &&
                   !mod_cond_i.minor_fault && mod_cond_i.has_address &&
                   mod_cond_i.configured;
  assign major_c = !mod_cond_i.self_test && mod_cond_i.major_fault;

  sequence s_slow_wrap;
    r_r.slow_cnt == CW'(SLOW_HALF - 1);
  endsequence

  chk_oper_green: assert property (@(posedge clk_i) disable iff (rst_i)
    oper_c |=> module_green_lamp_o && !module_red_lamp_o) // R2
    else $error("operational device not steady green");
  chk_major_red: assert property (@(posedge clk_i) disable iff (rst_i)
    major_c |=> module_red_lamp_o && !module_green_lamp_o) // R6
    else $error("major fault not steady red");
  chk_test_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    mod_cond_i.self_test |=> module_red_lamp_o != module_green_lamp_o) // R7
    else $error("self-test lamps not alternating");
  chk_slow_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    s_slow_wrap |=> r_r.slow_ph != $past(r_r.slow_ph)) // R16
    else $error("slow blink phase did not toggle");
  chk_slow_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(r_r.slow_cnt == CW'(SLOW_HALF - 1)) |=> $stable(r_r.slow_ph)) // R3
    else $error("slow blink phase toggled early");
  chk_fast_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(r_r.fast_cnt == CW'(FAST_HALF - 1)) |=> $stable(r_r.fast_ph)) // R4
    else $error("fast blink phase toggled early");
  chk_minor_red: assert property (@(posedge clk_i) disable iff (rst_i)
    !mod_cond_i.self_test && !mod_cond_i.major_fault &&
    mod_cond_i.minor_fault |=> module_red_lamp_o == $past(r_r.slow_ph)) // R5
    else $error("minor fault red not following slow blink");
  chk_conn_green: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_one_cond_i.self_test && port_one_cond_i.has_address &&
    !port_one_cond_i.dup_address && !u_port_one.r_r.tmo_pend &&
    port_one_cond_i.conn_up |=> port_one_link_lamp_o) // R9
    else $error("connected port not steady green");

  // ==========================================================
  // further checks on the module indicator and blink generators
  logic minor_c;
  logic noadr_c;
  logic stby_c;
  assign minor_c = !mod_cond_i.self_test && !mod_cond_i.major_fault &&
                   mod_cond_i.minor_fault;
  assign noadr_c = !mod_cond_i.self_test && !mod_cond_i.major_fault &&
                   !mod_cond_i.minor_fault && !mod_cond_i.has_address;
  assign stby_c  = !mod_cond_i.self_test && !mod_cond_i.major_fault &&
                   !mod_cond_i.minor_fault && mod_cond_i.has_address &&
                   !mod_cond_i.configured;

  sequence s_fast_wrap;
    r_r.fast_cnt == CW'(FAST_HALF - 1);
  endsequence

  chk_stby_slow: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_c |=> module_green_lamp_o == $past(r_r.slow_ph)) // R3
    else $error("standby green not following slow blink");
  chk_stby_red_off: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_c |=> !module_red_lamp_o) // R3
    else $error("standby lit the red lamp");
  chk_noadr_fast: assert property (@(posedge clk_i) disable iff (rst_i)
    noadr_c |=> module_green_lamp_o == $past(r_r.fast_ph)) // R4
    else $error("missing address green not following fast blink");
  chk_noadr_red_off: assert property (@(posedge clk_i) disable iff (rst_i)
    noadr_c |=> !module_red_lamp_o) // R4
    else $error("missing address lit the red lamp");
  chk_minor_green_off: assert property (@(posedge clk_i) disable iff (rst_i)
    minor_c |=> !module_green_lamp_o) // R5
    else $error("minor fault lit the green lamp");
  chk_test_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    mod_cond_i.self_test |=> module_red_lamp_o == $past(r_r.slow_ph)) // R7
    else $error("self-test red not following slow blink");
  chk_fast_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fast_wrap |=> r_r.fast_ph != $past(r_r.fast_ph)) // R16
    else $error("fast blink phase did not toggle");
  chk_slow_range: assert property (@(posedge clk_i) disable iff (rst_i)
    r_r.slow_cnt <= CW'(SLOW_HALF - 1)) // R16
    else $error("slow blink counter past its half period");
  chk_fast_range: assert property (@(posedge clk_i) disable iff (rst_i)
    r_r.fast_cnt <= CW'(FAST_HALF - 1)) // R16
    else $error("fast blink counter past its half period");

  // ==========================================================
  // further checks on the network indicators
  logic p1_live_c;
  logic p2_live_c;
  // live: address held, no self-test and no duplicate
  assign p1_live_c = !port_one_cond_i.self_test &&
                     port_one_cond_i.has_address &&
                     !port_one_cond_i.dup_address;
  assign p2_live_c = !port_two_cond_i.self_test &&
                     port_two_cond_i.has_address &&
                     !port_two_cond_i.dup_address;

  sequence s_p1_tmo_evt;
    port_one_cond_i.timeout_evt;
  endsequence
  sequence s_p2_tmo_evt;
    port_two_cond_i.timeout_evt;
  endsequence
  sequence s_p1_reest;
    port_one_cond_i.reestablished && !port_one_cond_i.timeout_evt;
  endsequence
  sequence s_p2_reest;
    port_two_cond_i.reestablished && !port_two_cond_i.timeout_evt;
  endsequence

  chk_p1_tmo_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_p1_tmo_evt |=> u_port_one.r_r.tmo_pend) // R11
    else $error("port one timeout not latched");
  chk_p2_tmo_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_p2_tmo_evt |=> u_port_two.r_r.tmo_pend) // R11
    else $error("port two timeout not latched");
  chk_p1_reest_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    s_p1_reest |=> !u_port_one.r_r.tmo_pend) // R12
    else $error("port one timeout kept after re-establish");
  chk_p2_reest_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    s_p2_reest |=> !u_port_two.r_r.tmo_pend) // R12
    else $error("port two timeout kept after re-establish");
  chk_p1_tmo_yellow: assert property (@(posedge clk_i) disable iff (rst_i)
    p1_live_c && u_port_one.r_r.tmo_pend
    |=> port_one_activity_lamp_o == $past(r_r.slow_ph) &&
        !port_one_link_lamp_o) // R11
    else $error("port one timeout not flashing yellow");
  chk_p2_tmo_yellow: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_live_c && u_port_two.r_r.tmo_pend
    |=> port_two_activity_lamp_o == $past(r_r.slow_ph) &&
        !port_two_link_lamp_o) // R11
    else $error("port two timeout not flashing yellow");
  chk_p1_nocon_flash: assert property (@(posedge clk_i) disable iff (rst_i)
    p1_live_c && !u_port_one.r_r.tmo_pend && !port_one_cond_i.conn_up
    |=> port_one_link_lamp_o == $past(r_r.slow_ph) &&
        !port_one_activity_lamp_o) // R10
    else $error("port one idle green not following slow blink");
  chk_p2_nocon_flash: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_live_c && !u_port_two.r_r.tmo_pend && !port_two_cond_i.conn_up
    |=> port_two_link_lamp_o == $past(r_r.slow_ph) &&
        !port_two_activity_lamp_o) // R10
    else $error("port two idle green not following slow blink");
  chk_p2_conn_green: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_live_c && !u_port_two.r_r.tmo_pend && port_two_cond_i.conn_up
    |=> port_two_link_lamp_o && !port_two_activity_lamp_o) // R9
    else $error("port two connected not steady green");
  chk_p1_test_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    port_one_cond_i.self_test
    |=> port_one_activity_lamp_o != port_one_link_lamp_o) // R14
    else $error("port one self-test lamps not alternating");
  chk_p2_test_alt: assert property (@(posedge clk_i) disable iff (rst_i)
    port_two_cond_i.self_test
    |=> port_two_activity_lamp_o != port_two_link_lamp_o) // R14
    else $error("port two self-test lamps not alternating");

endmodule

// file: sid_lamp_obs.sv
// operator model: watches the six lamps over a window and classifies each
// assumes WIN=32 cycles, SLOW_HALF=8 and FAST_HALF=2 at the indicator
`timescale 1ns/1ns

module sid_lamp_obs #(
  parameter int WIN = 32
)(
  // clock and control
  input  wire logic        clk_i,
  input  wire logic        start_i,
  // lamps {mod green, mod red, p1 act, p1 link, p2 act, p2 link}
  input  wire logic [5:0]  lamp_i,
  // result {overlap[2:0], class per lamp}
  output logic             valid_o,
  output logic [20:0]      res_o
);
  int         on_n[6];
  int         tog_n[6];
  int         cnt = 0;
  logic [2:0] ovl;
  logic [5:0] prev;

  // 0 dark, 3 steady, 1 slow flash, 2 fast flash, 4 anything else
  function automatic logic [2:0] cls(int on, int tg);
    if (on == 0) return 3'h0;
    if (on == WIN) return 3'h3;
    if (on == WIN / 2 && tg <= 5) return 3'h1;
    if (on == WIN / 2 && tg >= 15) return 3'h2;
    return 3'h4;
  endfunction

  initial valid_o = 1'b0;

  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (start_i) begin
      cnt = WIN;
      ovl = 3'h0;
      prev = lamp_i;
      for (int i = 0; i < 6; i++) begin
        on_n[i] = 0;
        tog_n[i] = 0;
      end
    end
    if (cnt > 0) begin
      for (int i = 0; i < 6; i++) begin
        on_n[i] += int'(lamp_i[i]);
        tog_n[i] += int'(lamp_i[i] != prev[i]);
      end
      // both lamps of one indicator lit together breaks alternation
      ovl |= {&lamp_i[5:4], &lamp_i[3:2], &lamp_i[1:0]};
      prev = lamp_i;
      cnt--;
      if (cnt == 0) begin
        valid_o <= 1'b1;
        res_o[20:18] <= ovl;
        for (int i = 0; i < 6; i++) begin
          res_o[3*i+:3] <= cls(on_n[i], tog_n[i]);
        end
      end
    end
  end
endmodule

// file: tb_top.sv
// self-checking bench for the status lamp driver
// assumes shortened blink halves so a 32 cycle window holds whole periods
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_top
  import sid_pkg::*;
;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  sid_module_cond_type mc = '0;
  sid_port_cond_type   p1 = '0;
  sid_port_cond_type   p2 = '0;
  logic [5:0]          lamps;
  logic                start = 1'b0;
  logic                valid;
  logic [20:0]         res;
  logic [20:0]         e;
  logic [20:0]         exp_q[$];
  logic [1:0]          pend = 2'h0;
  int                  n_fail = 0;
  int                  num_checks = 0;

  // =========================================================
  // design and operator model
  sid_status_indicator #(.SLOW_HALF(8), .FAST_HALF(2)) i_sid_status_indicator (
    .clk_i(clk_i), .rst_i(rst_i), .mod_cond_i(mc), .port_one_cond_i(p1),
    .port_two_cond_i(p2), .module_green_lamp_o(lamps[5]),
    .module_red_lamp_o(lamps[4]), .port_one_activity_lamp_o(lamps[3]),
    .port_one_link_lamp_o(lamps[2]), .port_two_activity_lamp_o(lamps[1]),
    .port_two_link_lamp_o(lamps[0]));
  sid_lamp_obs i_sid_lamp_obs (.clk_i(clk_i), .start_i(start),
    .lamp_i(lamps), .valid_o(valid), .res_o(res));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // =========================================================
  // expected classes {first lamp, second lamp}
  function automatic logic [5:0] mod_exp(sid_module_cond_type c);
    if (c.self_test) return 6'h09;
    if (c.major_fault) return 6'h03;
    if (c.minor_fault) return 6'h01;
    if (!c.has_address) return 6'h10;
    if (!c.configured) return 6'h08;
    return 6'h18;
  endfunction

  function automatic logic [5:0] port_exp(sid_port_cond_type c, logic pd);
    if (c.self_test) return 6'h09;
    if (!c.has_address) return 6'h00;
    if (c.dup_address) return 6'h18;
    if (pd) return 6'h08;
    if (c.conn_up) return 6'h03;
    return 6'h01;
  endfunction

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // inputs hold for the whole window; pulses last one cycle
  task automatic step(logic [4:0] m, logic [5:0] a, logic [5:0] b);
    @(negedge clk_i);
    mc = m;
    p1 = a;
    p2 = b;
    pend[1] = a[1] | (pend[1] & ~a[0]);
    pend[0] = b[1] | (pend[0] & ~b[0]);
    @(negedge clk_i);
    p1.timeout_evt = 1'b0;
    p1.reestablished = 1'b0;
    p2.timeout_evt = 1'b0;
    p2.reestablished = 1'b0;
    repeat (3) @(negedge clk_i);
    start = 1'b1;
    exp_q.push_back({3'h0, mod_exp(mc), port_exp(p1, pend[1]),
                     port_exp(p2, pend[0])});
    @(negedge clk_i);
    start = 1'b0;
    repeat (33) @(negedge clk_i);
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    rst_i = 1'b1;
    pend = 2'h0;
    repeat (20) @(negedge clk_i);
    `CHK("lamps in reset", 6'h00, lamps)
    rst_i = 1'b0;
  endtask

  // =========================================================
  // result watcher
  initial begin
    forever begin
      @(posedge clk_i);
      #1;
      if (valid === 1'b1) begin
        e = exp_q.pop_front();
        `CHK("overlap", e[20:18], res[20:18])
        `CHK("module lamps", e[17:12], res[17:12])
        `CHK("port one lamps", e[11:6], res[11:6])
        `CHK("port two lamps", e[5:0], res[5:0])
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end

  // =========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    // seeds the generator once; the value drawn here is not used
    r = $urandom(32'h7913);
    do_reset();
    step(5'h03, 6'h16, 6'h14);
    step(5'h03, 6'h04, 6'h14);
    step(5'h03, 6'h14, 6'h15);
    step(5'h03, 6'h15, 6'h17);
    do_reset();
    step(5'h03, 6'h14, 6'h2C);
    for (int k = 0; k < 30; k++) begin
      r = $urandom;
      step({&r[2:0], &r[4:3], &r[6:5], |r[8:7], r[9]},
           {&r[12:10], |r[14:13], &r[16:15], r[17], r[18] & r[19], r[20]},
           {&r[23:21], |r[25:24], &r[27:26], r[28], r[29] & r[30], r[31]});
      if (k == 15) do_reset();
    end
    for (int k = 0; k < 100 && exp_q.size() > 0; k++) @(posedge clk_i);
    if (exp_q.size() > 0) n_fail++;
    finish_test();
  end
endmodule
